// ===== hdl/add_sub.sv
// parameterised adder/subtractor with carry, half-carry and overflow
// assumes carry in means borrow in when subtracting
`timescale 1ns/1ps

module add_sub #(
  parameter int W = 8
) (
  // operands
  input  wire logic [W-1:0] a_i,
  input  wire logic [W-1:0] b_i,
  input  wire logic         cin_i,
  input  wire logic         sub_i,
  // results
  output logic [W-1:0]      res_o,
  output logic              carry_o,
  output logic              half_o,
  output logic              ovf_o
);

  logic [W-1:0] b_eff;
  logic         c_eff;
  logic [W:0]   full;
  logic [4:0]   nib;

  // subtract as a + ~b + ~borrow, then invert carries into borrows
  assign b_eff   = sub_i ? ~b_i : b_i;
  assign c_eff   = sub_i ? ~cin_i : cin_i;
  assign full    = {1'b0, a_i} + {1'b0, b_eff} + {{W{1'b0}}, c_eff};
  assign nib     = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
  assign res_o   = full[W-1:0];
  assign carry_o = full[W] ^ sub_i;
  assign half_o  = nib[4] ^ sub_i;
  assign ovf_o   = (a_i[W-1] == b_eff[W-1]) && (full[W-1] != a_i[W-1]);

endmodule

// ===== hdl/alu_branch_skip_execute.sv
// execute stage for arithmetic, logic, jump, call, return and skip instructions
// assumes decode holds operands valid in the cycle start_i is taken
//
// What this block does
// - add and add-with-carry: one cycle, ZCNVH
// - word add immediate: two cycles, ZCNVS
// - subtract register or constant: one cycle, ZCNVH
// - word subtract immediate: two cycles, ZCNVS
// - subtract with carry: one cycle, ZCNVH
// - and, or, xor: one cycle, ZNV only
// - clear bits: and with inverted mask
// - test: and with itself, no write
// - pointer jump: pc from Z, two cycles
// - pointer call: push, pc from Z, three
// - compare skip equal: skip, 1/2/3 cycles
// - compares: flags only, no write-back, one cycle
// - skip when register bit clear
// - skip when register bit set
// - skip when io bit clear
// - skip when io bit set
`timescale 1ns/1ps
`include "alu_consts.svh"

module alu_branch_skip_execute (
  // clock, reset, enable
  input  wire logic               mclk_i,
  input  wire logic               reset_n_i,
  input  wire logic               ce_i,
  // request from decode
  input  wire logic               start_i,
  input  wire alu_pkg::instr_type instr_i,
  input  wire logic [7:0]         sreg_i,
  // answer to register file and fetch
  output logic                    ready_o,
  output logic                    done_o,
  output alu_pkg::result_type     res_o
);
  import alu_pkg::*;

  logic [7:0]  a8;
  logic [7:0]  b8;
  logic [7:0]  s8;
  logic [7:0]  lg;
  logic        cin8;
  logic        sub8;
  logic        c8;
  logic        h8;
  logic        v8;
  logic [15:0] kw;
  logic [15:0] w16;
  logic [15:0] rel;
  logic        cw;
  logic        vw;
  logic        word_sub;
  logic        chain;
  logic        skip;
  logic        take;
  logic        busy;
  logic [2:0]  cnt;
  logic [2:0]  next_cycles;
  result_type  next_res;
  result_type  pending;
  instr_type   held;
  logic [7:0]  held_sreg;
  logic [2:0]  elapsed;

  assign take     = ce_i & start_i & ready_o;
  assign kw       = {`WORD_K_PAD, instr_i.imm[5:0]};
  assign rel      = {{`REL_PAD{instr_i.offset[11]}}, instr_i.offset};
  assign word_sub = (instr_i.op == subtract_immediate_word);

  add_sub #(.W(8)) alu8 (
    .a_i     (a8),
    .b_i     (b8),
    .cin_i   (cin8),
    .sub_i   (sub8),
    .res_o   (s8),
    .carry_o (c8),
    .half_o  (h8),
    .ovf_o   (v8)
  );

  add_sub #(.W(16)) word16 (
    .a_i     (instr_i.pair),
    .b_i     (kw),
    .cin_i   (1'b0),
    .sub_i   (word_sub),
    .res_o   (w16),
    .carry_o (cw),
    .half_o  (),
    .ovf_o   (vw)
  );

  // operand routing into the shared byte adder
  always_comb
  begin
    a8    = instr_i.rd;
    b8    = instr_i.rr;
    cin8  = 1'b0;
    sub8  = 1'b0;
    chain = 1'b0;
    case (instr_i.op)
      add_with_carry:
        cin8 = sreg_i[`FLAG_C];
      sub_regs, compare_regs:
        sub8 = 1'b1;
      subtract_immediate, compare_immediate:
      begin
        sub8 = 1'b1;
        b8   = instr_i.imm;
      end
      subtract_with_carry, compare_with_carry:
      begin
        sub8  = 1'b1;
        cin8  = sreg_i[`FLAG_C];
        chain = 1'b1;
      end
      subtract_immediate_with_carry:
      begin
        sub8  = 1'b1;
        b8    = instr_i.imm;
        cin8  = sreg_i[`FLAG_C];
        chain = 1'b1;
      end
      twos_complement:
      begin
        a8   = `ZERO8;
        b8   = instr_i.rd;
        sub8 = 1'b1;
      end
      increment:
        b8 = `ONE8;
      decrement:
      begin
        b8   = `ONE8;
        sub8 = 1'b1;
      end
      default:
        b8 = instr_i.rr;
    endcase
  end

  // logic unit
  always_comb
  begin
    case (instr_i.op)
      and_regs:        lg = instr_i.rd & instr_i.rr;
      and_immediate:   lg = instr_i.rd & instr_i.imm;
      or_regs:         lg = instr_i.rd | instr_i.rr;
      or_immediate:    lg = instr_i.rd | instr_i.imm;
      set_bits_mask:   lg = instr_i.rd | instr_i.imm;
      exclusive_or:    lg = instr_i.rd ^ instr_i.rr;
      clear_bits_mask: lg = instr_i.rd & ~instr_i.imm;
      zero_minus_test: lg = instr_i.rd & instr_i.rd;
      clear_reg:       lg = instr_i.rd ^ instr_i.rd;
      default:         lg = `ZERO8;
    endcase
  end

  // skip condition
  always_comb
  begin
    case (instr_i.op)
      compare_skip_equal: skip = (instr_i.rd == instr_i.rr);
      skip_reg_bit_clear: skip = !instr_i.rr[instr_i.bit_sel];
      skip_reg_bit_set:   skip = instr_i.rr[instr_i.bit_sel];
      skip_io_bit_clear:  skip = !instr_i.io_bit;
      skip_io_bit_set:    skip = instr_i.io_bit;
      default:            skip = 1'b0;
    endcase
  end

  // result, flags, next pc and cycle count
  always_comb
  begin
    next_res           = '0;
    next_res.sreg      = sreg_i;
    next_res.pc        = instr_i.pc + `PC_STEP;
    next_res.rd_data   = s8;
    next_res.word_data = w16;
    next_res.push_data = instr_i.pc + `PC_STEP;
    next_cycles        = `CYC_ONE;
    case (instr_i.op)
      add_regs, add_with_carry, sub_regs, subtract_immediate,
      subtract_with_carry, subtract_immediate_with_carry, twos_complement,
      compare_regs, compare_with_carry, compare_immediate:
      begin
        // subtract and compare with carry keep Z only if it was already set
        next_res.rd_wr = !(instr_i.op inside {compare_regs, compare_with_carry,
                                              compare_immediate});
        next_res.sreg[`FLAG_Z] = (s8 == `ZERO8) & (!chain | sreg_i[`FLAG_Z]);
        next_res.sreg[`FLAG_C] = c8;
        next_res.sreg[`FLAG_N] = s8[7];
        next_res.sreg[`FLAG_V] = v8;
        next_res.sreg[`FLAG_H] = h8;
      end
      increment, decrement:
      begin
        next_res.rd_wr         = 1'b1;
        next_res.sreg[`FLAG_Z] = (s8 == `ZERO8);
        next_res.sreg[`FLAG_N] = s8[7];
        next_res.sreg[`FLAG_V] = v8;
      end
      add_immediate_word, subtract_immediate_word:
      begin
        next_res.word_wr       = 1'b1;
        next_res.sreg[`FLAG_Z] = (w16 == {`ZERO8, `ZERO8});
        next_res.sreg[`FLAG_C] = cw;
        next_res.sreg[`FLAG_N] = w16[15];
        next_res.sreg[`FLAG_V] = vw;
        next_res.sreg[`FLAG_S] = w16[15] ^ vw;
        next_cycles            = `CYC_TWO;
      end
      and_regs, and_immediate, or_regs, or_immediate, exclusive_or,
      set_bits_mask, clear_bits_mask, zero_minus_test, clear_reg:
      begin
        next_res.rd_data       = lg;
        next_res.rd_wr         = (instr_i.op != zero_minus_test);
        next_res.sreg[`FLAG_Z] = (lg == `ZERO8);
        next_res.sreg[`FLAG_N] = lg[7];
        next_res.sreg[`FLAG_V] = 1'b0;
      end
      ones_complement:
      begin
        next_res.rd_data       = ~instr_i.rd;
        next_res.rd_wr         = 1'b1;
        next_res.sreg[`FLAG_Z] = (instr_i.rd == `ALL_ONES);
        next_res.sreg[`FLAG_N] = !instr_i.rd[7];
        next_res.sreg[`FLAG_V] = 1'b0;
        next_res.sreg[`FLAG_C] = 1'b1;
      end
      set_all_ones:
      begin
        next_res.rd_data = `ALL_ONES;
        next_res.rd_wr   = 1'b1;
      end
      relative_jump:
      begin
        next_res.pc = instr_i.pc + rel + `PC_STEP;
        next_cycles = `CYC_TWO;
      end
      relative_call:
      begin
        next_res.pc   = instr_i.pc + rel + `PC_STEP;
        next_res.push = 1'b1;
        next_cycles   = `CYC_THREE;
      end
      pointer_jump:
      begin
        next_res.pc = instr_i.zptr;
        next_cycles = `CYC_TWO;
      end
      pointer_call:
      begin
        next_res.pc   = instr_i.zptr;
        next_res.push = 1'b1;
        next_cycles   = `CYC_THREE;
      end
      subroutine_return, interrupt_return:
      begin
        next_res.pc  = instr_i.ret_addr;
        next_res.pop = 1'b1;
        next_cycles  = `CYC_FOUR;
        if (instr_i.op == interrupt_return)
          next_res.sreg[`FLAG_I] = 1'b1;
      end
      compare_skip_equal, skip_reg_bit_clear, skip_reg_bit_set,
      skip_io_bit_clear, skip_io_bit_set:
      begin
        // a skipped two-word instruction costs one more fetch cycle
        if (skip)
        begin
          next_res.pc = instr_i.pc + (instr_i.next_two_word ? `SKIP_THREE : `SKIP_TWO);
          next_cycles = instr_i.next_two_word ? `CYC_THREE : `CYC_TWO;
        end
      end
      default:
        next_cycles = `CYC_ONE;
    endcase
  end

  // sequencing: hold answer until its last cycle
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      busy    <= 1'b0;
      ready_o <= 1'b1;
      cnt     <= `CYC_ONE;
      done_o  <= 1'b0;
      pending <= '0;
    end
    else if (ce_i)
    begin
      if (take)
      begin
        pending <= next_res;
        busy    <= (next_cycles != `CYC_ONE);
        ready_o <= (next_cycles == `CYC_ONE);
        cnt     <= next_cycles - `CYC_ONE;
        done_o  <= (next_cycles == `CYC_ONE);
      end
      else if (busy)
      begin
        cnt     <= cnt - `CYC_ONE;
        busy    <= (cnt != `CYC_ONE);
        ready_o <= (cnt == `CYC_ONE);
        done_o  <= (cnt == `CYC_ONE);
      end
      else
        done_o <= 1'b0;
    end
  end

  // answer register
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      res_o <= '0;
    else if (ce_i && take && next_cycles == `CYC_ONE)
      res_o <= next_res;
    else if (ce_i && busy && cnt == `CYC_ONE)
      res_o <= pending;
  end

  // checking aid: the taken instruction and its age in cycles
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      held      <= '0;
      held_sreg <= `SREG_RESET;
      elapsed   <= 3'd0;
    end
    else if (ce_i)
    begin
      if (take)
      begin
        held      <= instr_i;
        held_sreg <= sreg_i;
        elapsed   <= `CYC_ONE;
      end
      else if (busy)
        elapsed <= elapsed + `CYC_ONE;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  add_sum_timing_a: assert property (done_o
    && held.op inside {add_regs, add_with_carry} |->
    elapsed == `CYC_ONE && res_o.rd_wr && res_o.rd_data == held.rd + held.rr
    + {7'h00, held.op == add_with_carry && held_sreg[`FLAG_C]}) else $error("add wrong");
  word_add_a: assert property (done_o && held.op == add_immediate_word |->
    elapsed == `CYC_TWO && res_o.word_wr && res_o.word_data == held.pair + {`WORD_K_PAD,
    held.imm[5:0]} && res_o.sreg[`FLAG_S] == (res_o.sreg[`FLAG_N] ^ res_o.sreg[`FLAG_V]))
    else $error("word add wrong");
  sub_borrow_a: assert property (done_o && held.op == subtract_immediate |->
    res_o.rd_data == held.rd - held.imm && res_o.sreg[`FLAG_C] == (held.rd < held.imm))
    else $error("subtract wrong");
  word_sub_a: assert property (done_o && held.op == subtract_immediate_word |->
    elapsed == `CYC_TWO && res_o.word_data == held.pair - {`WORD_K_PAD, held.imm[5:0]})
    else $error("word subtract wrong");
  carry_sub_a: assert property (done_o && held.op == subtract_with_carry |->
    res_o.rd_data == held.rd - held.rr - {7'h00, held_sreg[`FLAG_C]}
    && (!res_o.sreg[`FLAG_Z] || held_sreg[`FLAG_Z])) else $error("carry subtract wrong");
  logic_flags_a: assert property (done_o
    && held.op inside {and_regs, or_regs, exclusive_or}
    |-> !res_o.sreg[`FLAG_V] && res_o.sreg[`FLAG_C] == held_sreg[`FLAG_C])
    else $error("logic flags wrong");
  clear_bits_a: assert property (done_o && held.op == clear_bits_mask |->
    res_o.rd_data == (held.rd & ~held.imm)) else $error("clear bits wrong");
  test_no_write_a: assert property (done_o && held.op == zero_minus_test |->
    !res_o.rd_wr && res_o.sreg[`FLAG_Z] == (held.rd == `ZERO8)) else $error("test wrong");
  pointer_jump_a: assert property (done_o && held.op == pointer_jump |->
    elapsed == `CYC_TWO && res_o.pc == held.zptr && res_o.sreg == held_sreg)
    else $error("pointer jump wrong");
  pointer_call_a: assert property (done_o && held.op == pointer_call |->
    elapsed == `CYC_THREE && res_o.push && res_o.push_data == held.pc + `PC_STEP)
    else $error("pointer call wrong");
  skip_equal_a: assert property (done_o && held.op == compare_skip_equal
    && held.rd == held.rr && !held.next_two_word |-> elapsed == `CYC_TWO
    && res_o.pc == held.pc + `SKIP_TWO) else $error("skip equal wrong");
  compare_only_a: assert property (done_o && held.op == compare_immediate |->
    !res_o.rd_wr && res_o.sreg[`FLAG_Z] == (held.rd == held.imm)) else $error("compare wrong");
  reg_clear_skip_a: assert property (done_o && held.op == skip_reg_bit_clear
    && !held.rr[held.bit_sel] && held.next_two_word |-> elapsed == `CYC_THREE)
    else $error("bit clear skip wrong");
  reg_set_skip_a: assert property (done_o && held.op == skip_reg_bit_set
    && !held.rr[held.bit_sel] |-> res_o.pc == held.pc + `PC_STEP) else $error("no skip wrong");
  io_clear_skip_a: assert property (done_o && held.op == skip_io_bit_clear
    && held.io_bit |-> elapsed == `CYC_ONE) else $error("io clear skip wrong");
  io_set_skip_a: assert property (done_o && held.op == skip_io_bit_set && held.io_bit
    |-> res_o.sreg == held_sreg && res_o.pc != held.pc + `PC_STEP) else $error("io set wrong");
  rel_jump_a: assert property (done_o && held.op == relative_jump
    |-> elapsed == `CYC_TWO
    && res_o.pc == held.pc + {{`REL_PAD{held.offset[11]}}, held.offset} + `PC_STEP)
    else $error("relative jump wrong");
  int_return_a: assert property (done_o && held.op == interrupt_return |->
    elapsed == `CYC_FOUR && res_o.pop && res_o.sreg[`FLAG_I]) else $error("return wrong");
  set_ones_a: assert property (done_o && held.op == set_all_ones |->
    res_o.rd_data == `ALL_ONES && res_o.sreg == held_sreg) else $error("set ones wrong");
  freeze_a: assert property (!ce_i |=> $stable(res_o) && $stable(done_o))
    else $error("state moved while disabled");

endmodule

// ===== hdl/alu_consts.svh
// constants for the execute datapath: flag positions, reset values, cycle counts
// assumes it is included by bare name from design files
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH

// status register bit positions
`define FLAG_I 7
`define FLAG_T 6
`define FLAG_H 5
`define FLAG_S 4
`define FLAG_V 3
`define FLAG_N 2
`define FLAG_Z 1
`define FLAG_C 0

// reset values
`define SREG_RESET 8'h00

// data constants
`define ZERO8      8'h00
`define ONE8       8'h01
`define ALL_ONES   8'hff
`define WORD_K_PAD 10'h000
`define REL_PAD    4

// program counter steps
`define PC_STEP    16'h0001
`define SKIP_TWO   16'h0002
`define SKIP_THREE 16'h0003

// cycle counts
`define CYC_ONE   3'd1
`define CYC_TWO   3'd2
`define CYC_THREE 3'd3
`define CYC_FOUR  3'd4

`endif

// ===== hdl/alu_pkg.sv
// types shared by the execute datapath and its decode partner
// assumes decode fills one instr_type per issued instruction
package alu_pkg;

  typedef enum logic [5:0] {
    no_operation,
    add_regs,
    add_with_carry,
    add_immediate_word,
    sub_regs,
    subtract_immediate,
    subtract_immediate_word,
    subtract_with_carry,
    subtract_immediate_with_carry,
    and_regs,
    and_immediate,
    or_regs,
    or_immediate,
    exclusive_or,
    ones_complement,
    twos_complement,
    set_bits_mask,
    clear_bits_mask,
    increment,
    decrement,
    zero_minus_test,
    clear_reg,
    set_all_ones,
    relative_jump,
    pointer_jump,
    relative_call,
    pointer_call,
    subroutine_return,
    interrupt_return,
    compare_skip_equal,
    compare_regs,
    compare_with_carry,
    compare_immediate,
    skip_reg_bit_clear,
    skip_reg_bit_set,
    skip_io_bit_clear,
    skip_io_bit_set
  } op_type;

  typedef struct packed {
    op_type      op;
    logic [7:0]  rd;
    logic [7:0]  rr;
    logic [7:0]  imm;
    logic [15:0] pair;
    logic [11:0] offset;
    logic [2:0]  bit_sel;
    logic [15:0] pc;
    logic [15:0] zptr;
    logic [15:0] ret_addr;
    logic        io_bit;
    logic        next_two_word;
  } instr_type;

  typedef struct packed {
    logic [7:0]  rd_data;
    logic        rd_wr;
    logic [15:0] word_data;
    logic        word_wr;
    logic [7:0]  sreg;
    logic [15:0] pc;
    logic        push;
    logic [15:0] push_data;
    logic        pop;
  } result_type;

endpackage

// ===== tb/tb_alu_branch_skip_execute.sv
// self-checking bench for the execute datapath: corner table, then random ops
// assumes the design carries its own assertions; the bench only drives and compares
`timescale 1ns/1ps

module tb_alu_branch_skip_execute;
  import alu_pkg::*;

  logic        mclk_i;
  logic        reset_n_i;
  logic        ce_i;
  logic        start_i;
  instr_type   instr_i;
  logic [7:0]  sreg_i;
  logic        ready_o;
  logic        done_o;
  result_type  res_o;
  logic [15:0] lfsr;
  logic [15:0] ce_st;
  logic        ce_rand;
  int          errors;
  int          cmp_count;
  int          k;

  alu_branch_skip_execute DUT (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .start_i   (start_i),
    .instr_i   (instr_i),
    .sreg_i    (sreg_i),
    .ready_o   (ready_o),
    .done_o    (done_o),
    .res_o     (res_o)
  );

  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function logic [15:0] rnd();
    lfsr = lfsr_next(lfsr);
    return lfsr;
  endfunction

  // own generator state so the enable stream never races the data stream
  always @(posedge mclk_i)
  begin
    #1;
    ce_i <= ce_rand ? (ce_st[0] | ce_st[1]) : 1'b1;
    ce_st = lfsr_next(ce_st);
  end

  task report_and_stop();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic void model(input instr_type i, input logic [7:0] s,
                                output result_type r, output int cyc);
    logic [8:0]  w;
    logic [4:0]  h;
    logic [16:0] ww = '0;
    logic [7:0]  a = i.rd;
    logic [7:0]  b = i.rr;
    logic [7:0]  lv = 8'h00;
    logic        c = 1'b0;
    logic        sb = 1'b0;
    logic        ar = 1'b0;
    logic        cmp = 1'b0;
    logic        kz = 1'b0;
    logic        lg = 1'b0;
    logic        vv = 1'b0;
    logic        sk = 1'b0;
    r = '0;
    r.sreg = s;
    r.pc = i.pc + 16'h0001;
    case (i.op)
      add_regs:                      ar = 1'b1;
      add_with_carry:                {ar, c} = {1'b1, s[0]};
      sub_regs:                      {ar, sb} = 2'b11;
      subtract_immediate:            {ar, sb, b} = {2'b11, i.imm};
      subtract_with_carry:           {ar, sb, c, kz} = {2'b11, s[0], 1'b1};
      subtract_immediate_with_carry: {ar, sb, c, kz, b} = {2'b11, s[0], 1'b1, i.imm};
      compare_regs:                  {ar, sb, cmp} = 3'b111;
      compare_with_carry:            {ar, sb, c, kz, cmp} = {2'b11, s[0], 2'b11};
      compare_immediate:             {ar, sb, cmp, b} = {3'b111, i.imm};
      twos_complement:               {ar, sb, a, b} = {2'b11, 8'h00, i.rd};
      and_regs:                      {lg, lv} = {1'b1, i.rd & i.rr};
      and_immediate:                 {lg, lv} = {1'b1, i.rd & i.imm};
      or_regs:                       {lg, lv} = {1'b1, i.rd | i.rr};
      or_immediate, set_bits_mask:   {lg, lv} = {1'b1, i.rd | i.imm};
      exclusive_or:                  {lg, lv} = {1'b1, i.rd ^ i.rr};
      clear_bits_mask:               {lg, lv} = {1'b1, i.rd & ~i.imm};
      zero_minus_test:               {lg, cmp, lv} = {2'b11, i.rd};
      clear_reg:                     {lg, lv} = {1'b1, 8'h00};
      ones_complement:               {lg, lv, r.sreg[0]} = {1'b1, ~i.rd, 1'b1};
      increment:                     {lg, lv, vv} = {1'b1, i.rd + 8'h01, i.rd == 8'h7f};
      decrement:                     {lg, lv, vv} = {1'b1, i.rd - 8'h01, i.rd == 8'h80};
      set_all_ones:                  {r.rd_wr, r.rd_data} = {1'b1, 8'hff};
      add_immediate_word:            ww = {1'b0, i.pair} + {11'h000, i.imm[5:0]};
      subtract_immediate_word:       ww = {1'b0, i.pair} - {11'h000, i.imm[5:0]};
      relative_jump, relative_call:  r.pc = r.pc + {{4{i.offset[11]}}, i.offset};
      pointer_jump, pointer_call:    r.pc = i.zptr;
      subroutine_return:             {r.pop, r.pc} = {1'b1, i.ret_addr};
      interrupt_return:              {r.pop, r.pc, r.sreg[7]} = {1'b1, i.ret_addr, 1'b1};
      compare_skip_equal:            sk = i.rd == i.rr;
      skip_reg_bit_clear:            sk = !i.rr[i.bit_sel];
      skip_reg_bit_set:              sk = i.rr[i.bit_sel];
      skip_io_bit_clear:             sk = !i.io_bit;
      skip_io_bit_set:               sk = i.io_bit;
      default:                       ;
    endcase
    case (i.op)
      add_immediate_word, subtract_immediate_word, relative_jump, pointer_jump: cyc = 2;
      relative_call, pointer_call:            cyc = 3;
      subroutine_return, interrupt_return:    cyc = 4;
      default:                                cyc = 1;
    endcase
    if (i.op inside {relative_call, pointer_call})
      {r.push, r.push_data} = {1'b1, i.pc + 16'h0001};
    if (ar)
    begin
      w = sb ? {1'b0, a} - {1'b0, b} - {8'h00, c} : {1'b0, a} + {1'b0, b} + {8'h00, c};
      h = sb ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c}
             : {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
      {r.rd_wr, r.rd_data} = {!cmp, w[7:0]};
      r.sreg[5:0] = {h[4], s[4], ((a[7] ^ b[7]) == sb) && (w[7] != a[7]), w[7],
                     (w[7:0] == 8'h00) && (!kz || s[1]), w[8]};
    end
    if (lg)
    begin
      {r.rd_wr, r.rd_data} = {!cmp, lv};
      r.sreg[3:1] = {vv, lv[7], lv == 8'h00};
    end
    if (i.op inside {add_immediate_word, subtract_immediate_word})
    begin
      {r.word_wr, r.word_data} = {1'b1, ww[15:0]};
      r.sreg[3] = (i.pair[15] != ww[15]) && (i.pair[15] == (i.op == subtract_immediate_word));
      r.sreg[2:0] = {ww[15], ww[15:0] == 16'h0000, ww[16]};
      r.sreg[4] = r.sreg[2] ^ r.sreg[3];
    end
    if (sk)
    begin
      r.pc = i.pc + (i.next_two_word ? 16'h0003 : 16'h0002);
      cyc = i.next_two_word ? 3 : 2;
    end
  endfunction

  function instr_type rand_instr(input op_type o);
    instr_type  i;
    logic [111:0] v;
    v = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    i = v[110:0];
    i.op = o;
    if (o inside {skip_reg_bit_clear, skip_reg_bit_set} || (o == compare_skip_equal && v[0]))
      i.rd = i.rr;
    return i;
  endfunction

  // entered just after a rising edge; the caller replaces start_i at once on return
  task run_op(input instr_type in, input logic [7:0] s);
    result_type er;
    int         ec;
    int         n;
    int         g;
    logic       ce_s;
    logic       rdy;
    model(in, s, er, ec);
    start_i = 1'b1;
    instr_i = in;
    sreg_i = s;
    n = 0;
    do
    begin
      @(negedge mclk_i);
      {ce_s, rdy} = {ce_i, ready_o};
      @(posedge mclk_i);
      #1;
      n++;
    end
    while (!(ce_s && rdy) && n < 40);
    if (!(ce_s && rdy))
    begin
      errors++;
      report_and_stop();
    end
    // held request while busy must be ignored, so show a different one
    if (!done_o)
      instr_i = ~in;
    // raw edge bound too, so a stuck enable cannot hang the run
    n = 1;
    g = 0;
    while (!done_o && n < 8 && g < 40)
    begin
      @(negedge mclk_i);
      ce_s = ce_i;
      @(posedge mclk_i);
      #1;
      g++;
      if (ce_s)
        n++;
    end
    if (!done_o)
    begin
      errors++;
      report_and_stop();
    end
    check("cycles", 16'(n), 16'(ec));
    check("ready", 16'(ready_o), 16'h0001);
    check("pc", res_o.pc, er.pc);
    check("sreg", 16'(res_o.sreg), 16'(er.sreg));
    check("strobes", 16'({res_o.rd_wr, res_o.word_wr, res_o.push, res_o.pop}),
          16'({er.rd_wr, er.word_wr, er.push, er.pop}));
    if (er.rd_wr)
      check("rd_data", 16'(res_o.rd_data), 16'(er.rd_data));
    if (er.word_wr)
      check("word_data", res_o.word_data, er.word_data);
    if (er.push)
      check("push_data", res_o.push_data, er.push_data);
  endtask

  task idle();
    logic ce_s;
    int   n;
    start_i = 1'b0;
    ce_s = 1'b0;
    n = 0;
    while (!ce_s && n < 20)
    begin
      @(negedge mclk_i);
      ce_s = ce_i;
      @(posedge mclk_i);
      #1;
      n++;
    end
    check("done pulse", 16'(done_o), 16'h0000);
  endtask

  task do_reset();
    reset_n_i = 1'b0;
    start_i = 1'b0;
    repeat (5) @(posedge mclk_i);
    #1;
    check("reset state", 16'({ready_o, done_o, res_o !== '0}), 16'h0004);
    reset_n_i = 1'b1;
  endtask

  task cc(input op_type o, input logic [7:0] d, input logic [7:0] q,
          input logic [7:0] m, input logic [7:0] s);
    instr_type i;
    i = rand_instr(o);
    {i.rd, i.rr, i.imm, i.pair} = {d, q, m, q, d};
    run_op(i, s);
  endtask

  initial
  begin
    errors = 0;
    cmp_count = 0;
    lfsr = 16'h0059;
    ce_st = 16'h0059;
    ce_rand = 1'b0;
    ce_i = 1'b1;
    instr_i = '0;
    sreg_i = 8'h00;
    do_reset();
    cc(add_regs, 8'h7f, 8'h01, 8'h00, 8'h00);
    cc(add_with_carry, 8'hff, 8'h00, 8'h00, 8'h01);
    cc(add_immediate_word, 8'hff, 8'hff, 8'hc1, 8'h00);
    cc(add_immediate_word, 8'hff, 8'h7f, 8'h01, 8'h00);
    cc(sub_regs, 8'h80, 8'h01, 8'h00, 8'h00);
    cc(subtract_immediate, 8'h10, 8'h00, 8'h01, 8'h00);
    cc(subtract_immediate_word, 8'h00, 8'h00, 8'h01, 8'h00);
    cc(subtract_with_carry, 8'h05, 8'h04, 8'h00, 8'h01);
    cc(subtract_immediate_with_carry, 8'h05, 8'h00, 8'h04, 8'h03);
    cc(exclusive_or, 8'h5a, 8'h5a, 8'h00, 8'hff);
    cc(clear_bits_mask, 8'hf0, 8'h00, 8'h80, 8'h00);
    cc(zero_minus_test, 8'h80, 8'h00, 8'h00, 8'h0a);
    cc(compare_with_carry, 8'h00, 8'h00, 8'h00, 8'h01);
    cc(twos_complement, 8'h80, 8'h00, 8'h00, 8'h00);
    cc(increment, 8'h7f, 8'h00, 8'h00, 8'h00);
    cc(decrement, 8'h80, 8'h00, 8'h00, 8'h00);
    cc(set_all_ones, 8'h12, 8'h00, 8'h00, 8'h3f);
    // every code eight times; second half with the clock enable stuttering
    for (k = 0; k < 37 * 8; k++)
    begin
      if (k == 37 * 4)
        ce_rand = 1'b1;
      run_op(rand_instr(op_type'(k % 37)), 8'(rnd()));
    end
    ce_rand = 1'b0;
    idle();
    // reset lands on a four-cycle return in flight
    start_i = 1'b1;
    instr_i = rand_instr(subroutine_return);
    @(posedge mclk_i);
    #1;
    do_reset();
    run_op(rand_instr(interrupt_return), 8'h00);
    idle();
    report_and_stop();
  end

endmodule
